/* File: dsa_top.sv */
// Dual solenoid amplifier control: APB register file, input conditioning, mode mapping,
// ramps, current scaling, dithered 1 kHz PWM, fault and status outputs.
// Assumes ADC codes arrive on pclk from an external converter; digital inputs are raw pins.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module dsa_top
  import dsa_pkg::*;
#(
  parameter int unsigned PWM_PERIOD = PWM_CYC,
  parameter int unsigned RAMP_TICK  = RAMP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [39:0] adc_code,
  input  wire logic [7:0]  din_pin,
  output logic      [1:0]  sol_pwm,
  output logic             fault_out,
  output logic             solb_out,
  output logic             led_yellow,
  output logic             led_red,
  output logic             nv_save,
  output logic             nv_restore
);
  logic [31:0] ctrl_r;
  logic [19:0] dith_hp_r;
  logic [10:0] dith_amp_r;
  dsa_sol_s    sol_r  [2];
  dsa_cond_s   cond_r [4];
  dsa_fix_s    fix_r  [7];
  logic [31:0] rd_nxt;
  logic        rd_ok;
  logic        acc;
  logic [7:0]  s1_r, s2_r, s3_r, din_r;
  logic [7:0]  din_act;
  logic [9:0]  cval [4];
  logic [9:0]  tgt [2];
  logic [1:0]  en;
  logic        sel_b;
  logic        fault_nxt;
  logic        rst_seen_r;
  logic [31:0] rtick_cnt_r;
  logic        rtick_r;
  logic [31:0] pwm_cnt_r;
  logic [19:0] dith_cnt_r;
  logic        dith_ph_r;
  logic [9:0]  cur_r [2];
  dsa_mode_e   mode;
  logic [1:0]  src;
  logic [2:0]  fsel;

  assign acc  = psel & penable & pready;
  assign mode = dsa_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign src  = ctrl_r[CTRL_SRC_LSB +: 2];

  // Register decode shared by the read mux and the write port
  logic        hit_lim;
  logic        hit_ramp;
  logic        hit_cond;
  logic        hit_fix;
  logic        lim_i;
  logic        ramp_i;
  logic [1:0]  cond_i;
  logic [2:0]  fix_i;

  assign hit_lim  = paddr == ADDR_LIM0 || paddr == ADDR_LIM0 + 8'h04;
  assign hit_ramp = paddr == ADDR_RAMP0 || paddr == ADDR_RAMP0 + 8'h04;
  assign hit_cond = paddr[7:4] == ADDR_COND0[7:4] && paddr[1:0] == 2'h0;
  assign hit_fix  = paddr >= ADDR_FIX1 && paddr < ADDR_FIX1 + 8'h1c && paddr[1:0] == 2'h0;
  // Solenoid A sits at the lower word of each pair: limits split on bit 4, ramps on bit 3
  assign lim_i    = paddr[4];
  assign ramp_i   = paddr[3];
  assign cond_i   = paddr[3:2];
  assign fix_i    = 3'(paddr[4:2] - 3'h4);

  // APB: one access cycle, answer registered during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // Read data is zero outside the answer cycle
      pready  <= psel & ~penable & ~pready;
      prdata  <= (psel & ~penable & ~pwrite & rd_ok) ? rd_nxt : 32'h0000_0000;
      pslverr <= psel & ~penable & ~rd_ok;
    end
  end

  // Read mux; unmapped or misaligned addresses answer with an error
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (paddr == ADDR_CTRL) begin
      // Save bit is a strobe and reads back as zero
      rd_nxt = {15'h0000, 1'b0, ctrl_r[15:0]};
    end else if (paddr == ADDR_STATUS) begin
      rd_nxt = {20'h00000, sel_b, fault_out, en, din_act};
    end else if (paddr == ADDR_DITHER) begin
      rd_nxt = {1'b0, dith_amp_r, dith_hp_r};
    end else if (hit_lim) begin
      rd_nxt = {5'h00, sol_r[lim_i].imax, 5'h00, sol_r[lim_i].imin};
    end else if (hit_ramp) begin
      rd_nxt = {6'h00, sol_r[ramp_i].rdn, 6'h00, sol_r[ramp_i].rup};
    end else if (hit_cond) begin
      rd_nxt = {6'h00, cond_r[cond_i].offs, 7'h00, cond_r[cond_i].gain};
    end else if (hit_fix) begin
      rd_nxt = {15'h0000, fix_r[fix_i].sol_b, 6'h00, fix_r[fix_i].val};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Register writes; save is a write-one pulse, not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r     <= CTRL_RST;
      dith_hp_r  <= DITH_HP_RST;
      dith_amp_r <= DITH_AMP_RST;
      nv_save    <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        sol_r[i] <= '{IMAX_RST, IMIN_RST, 10'h000, 10'h000};
      end
      for (int i = 0; i < 4; i++) begin
        cond_r[i] <= '{10'h000, GAIN_ONE};
      end
      for (int i = 0; i < 7; i++) begin
        fix_r[i] <= '{1'b0, 10'h000};
      end
    end else begin
      nv_save <= 1'b0;
      // STATUS is read-only: a write there is taken and dropped
      if (acc && pwrite && !pslverr) begin
        if (paddr == ADDR_CTRL) begin
          ctrl_r  <= {16'h0000, pwdata[15:0]};
          nv_save <= pwdata[CTRL_SAVE_BIT];
        end else if (paddr == ADDR_DITHER) begin
          dith_hp_r  <= pwdata[19:0];
          dith_amp_r <= pwdata[DITH_AMP_LSB +: 11];
        end else if (hit_lim) begin
          sol_r[lim_i].imin <= pwdata[10:0];
          sol_r[lim_i].imax <= pwdata[HI_LSB +: 11];
        end else if (hit_ramp) begin
          sol_r[ramp_i].rup <= pwdata[9:0];
          sol_r[ramp_i].rdn <= pwdata[HI_LSB +: 10];
        end else if (hit_cond) begin
          cond_r[cond_i] <= '{pwdata[HI_LSB +: 10], pwdata[8:0]};
        end else if (hit_fix) begin
          fix_r[fix_i] <= '{pwdata[HI_LSB], pwdata[9:0]};
        end
      end
    end
  end

  // Restore request once after reset release so the store reloads working data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen_r <= 1'b0;
      nv_restore <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
      nv_restore <= ~rst_seen_r;
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pins 0 and 1 idle high, so reset to that level to avoid a false assert
      s1_r  <= 8'h03;
      s2_r  <= 8'h03;
      s3_r  <= 8'h03;
      din_r <= 8'h03;
    end else begin
      s1_r <= din_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 8; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          din_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign din_act = {din_r[7:2], ~din_r[1:0]};

  // Input conditioning: offset, window gain, inversion
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cond
      logic [10:0] dif;
      logic [19:0] prod;
      logic [9:0]  win;
      // An input below its offset clamps to zero before the gain
      assign dif  = {1'b0, adc_code[g*CODE_W +: CODE_W]} - {1'b0, cond_r[g].offs};
      assign prod = dif[10] ? 20'h00000 : (20'(dif[9:0]) * 20'(cond_r[g].gain)) >> GAIN_SH;
      assign win  = (prod > 20'(CODE_MAX)) ? CODE_MAX : prod[9:0];
      assign cval[g] = ctrl_r[CTRL_INV_LSB + g] ? CODE_MAX - win : win;
    end
  endgenerate

  // Mode mapping and fixed preset override
  assign fsel = din_act[7:5];
  always_comb begin
    tgt[0] = 10'h000;
    tgt[1] = 10'h000;
    sel_b  = 1'b0;
    if (fsel != 3'h0) begin
      sel_b = fix_r[3'(fsel - 3'h1)].sol_b;
      tgt[sel_b] = fix_r[3'(fsel - 3'h1)].val;
    end else begin
      unique case (mode)
        MODE_SEL: begin
          sel_b = din_act[3];
          tgt[sel_b] = cval[src];
        end
        // Split and bipolar modes stretch each half back to full scale
        MODE_SPLIT: begin
          sel_b = cval[src] < CODE_MID;
          if (sel_b) begin
            tgt[1] = 10'((CODE_MID - 10'h001 - cval[src]) << 1);
          end else begin
            tgt[0] = 10'((cval[src] - CODE_MID) << 1) | {9'h000, cval[src][0]};
          end
        end
        MODE_BIPOL: begin
          sel_b = cval[2] < CODE_MID;
          if (sel_b) begin
            tgt[1] = 10'((CODE_MID - cval[2]) << 1) - 10'h001;
          end else begin
            tgt[0] = 10'((cval[2] - CODE_MID) << 1) | {9'h000, cval[2][0]};
          end
        end
        MODE_INDEP: begin
          tgt[0] = cval[0];
          tgt[1] = cval[1];
          // Yellow follows B while input 1 gives B a nonzero target
          sel_b  = cval[1] != 10'h000;
        end
      endcase
    end
  end

  // A disable input overrides the common enable
  assign en[0] = din_act[2] & ~din_act[0];
  assign en[1] = din_act[2] & ~din_act[1];

  // Cable break on enabled inputs
  // Fault is a level: it clears as soon as the code recovers
  always_comb begin
    fault_nxt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fault_nxt = fault_nxt | (ctrl_r[CTRL_CBRK_LSB + i] & (adc_code[i*CODE_W +: CODE_W] < CBRK_MIN));
    end
  end

  // Fault, status and LED outputs are registered copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_out  <= 1'b0;
      led_red    <= 1'b0;
      led_yellow <= 1'b0;
      solb_out   <= 1'b0;
    end else begin
      fault_out  <= fault_nxt;
      led_red    <= fault_nxt;
      led_yellow <= sel_b;
      solb_out   <= en[1] & sel_b & (cur_r[1] != 10'h000 || tgt[1] != 10'h000);
    end
  end

  // Ramp tick, PWM carrier and dither square wave timebases
  // The counters run free, so a target change waits up to one tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtick_cnt_r <= 32'h0000_0000;
      rtick_r     <= 1'b0;
      pwm_cnt_r   <= 32'h0000_0000;
      dith_cnt_r  <= 20'h00000;
      dith_ph_r   <= 1'b0;
    end else begin
      rtick_r     <= rtick_cnt_r == RAMP_TICK - 1;
      rtick_cnt_r <= (rtick_cnt_r == RAMP_TICK - 1) ? 32'h0000_0000 : rtick_cnt_r + 32'h0000_0001;
      pwm_cnt_r   <= (pwm_cnt_r == PWM_PERIOD - 1) ? 32'h0000_0000 : pwm_cnt_r + 32'h0000_0001;
      if (dith_cnt_r >= dith_hp_r) begin
        dith_cnt_r <= 20'h00000;
        dith_ph_r  <= ~dith_ph_r;
      end else begin
        dith_cnt_r <= dith_cnt_r + 20'h00001;
      end
    end
  end

  // Per solenoid: ramp, current scaling, dither, PWM compare
  generate
    for (g = 0; g < 2; g++) begin : g_sol
      logic [10:0] span;
      logic [20:0] scl;
      logic [11:0] isp;
      logic [12:0] idt;
      logic [10:0] ieff;
      logic [31:0] duty;
      logic [9:0]  up, dn;
      assign up = sol_r[g].rup;
      assign dn = sol_r[g].rdn;

      // A disabled output drops to zero at once and ramps up again from zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cur_r[g] <= 10'h000;
        end else if (!en[g]) begin
          cur_r[g] <= 10'h000;
        end else if (din_act[4] || (tgt[g] > cur_r[g] ? up == 10'h000 : dn == 10'h000)) begin
          cur_r[g] <= tgt[g];
        end else if (rtick_r) begin
          if (tgt[g] > cur_r[g]) begin
            cur_r[g] <= (tgt[g] - cur_r[g] > up) ? cur_r[g] + up : tgt[g];
          end else if (tgt[g] < cur_r[g]) begin
            cur_r[g] <= (cur_r[g] - tgt[g] > dn) ? cur_r[g] - dn : tgt[g];
          end
        end
      end

      assign span = (sol_r[g].imax > sol_r[g].imin) ? sol_r[g].imax - sol_r[g].imin : 11'h000;
      assign scl  = 21'(cur_r[g]) * 21'(span);
      assign isp  = 12'(sol_r[g].imin) + 12'(scl >> CODE_W);
      assign idt  = dith_ph_r ? 13'(isp) + 13'(dith_amp_r) : 13'(isp) - 13'(dith_amp_r);
      // Dither may push the current past either end of the range
      assign ieff = idt[12] ? 11'h000 : (idt > 13'(FULL_MA)) ? FULL_MA : idt[10:0];
      assign duty = (32'(ieff) * PWM_PERIOD) / 32'(FULL_MA);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sol_pwm[g] <= 1'b0;
        end else begin
          sol_pwm[g] <= en[g] & (pwm_cnt_r < duty);
        end
      end
    end
  endgenerate
endmodule

/* File: dsa_pkg.sv */
// Constants, register map and carrier types of the dual solenoid amplifier control.
// Assumes a 25 MHz pclk shared by the APB slave and all control logic.
package dsa_pkg;
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned PWM_HZ      = 1000;
  localparam int unsigned PWM_CYC     = CLK_HZ / PWM_HZ;
  localparam int unsigned RAMP_TICK_US = 1000;
  localparam int unsigned RAMP_CYC    = (CLK_HZ / 1_000_000) * RAMP_TICK_US;

  localparam int unsigned CODE_W   = 10;
  localparam int unsigned MA_W     = 11;
  localparam logic [9:0]  CODE_MAX = 10'h3ff;
  localparam logic [9:0]  CODE_MID = 10'h200;
  localparam logic [10:0] FULL_MA  = 11'h708;
  localparam logic [9:0]  CBRK_MIN = 10'h0cc;
  localparam logic [8:0]  GAIN_ONE = 9'h080;
  localparam int unsigned GAIN_SH  = 7;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DITHER = 8'h08;
  localparam logic [7:0] ADDR_LIM0   = 8'h0c;
  localparam logic [7:0] ADDR_RAMP0  = 8'h14;
  localparam logic [7:0] ADDR_COND0  = 8'h20;
  localparam logic [7:0] ADDR_FIX1   = 8'h30;

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SRC_LSB  = 2;
  localparam int unsigned CTRL_INV_LSB  = 4;
  localparam int unsigned CTRL_CBRK_LSB = 8;
  localparam int unsigned CTRL_SAVE_BIT = 16;
  localparam int unsigned HI_LSB        = 16;
  localparam int unsigned DITH_AMP_LSB  = 20;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [19:0] DITH_HP_RST = 20'h0c350;
  localparam logic [10:0] DITH_AMP_RST = 11'h000;
  localparam logic [10:0] IMAX_RST   = 11'h708;
  localparam logic [10:0] IMIN_RST   = 11'h000;

  typedef enum logic [1:0] {
    MODE_SEL   = 2'h0,
    MODE_SPLIT = 2'h1,
    MODE_BIPOL = 2'h2,
    MODE_INDEP = 2'h3
  } dsa_mode_e;

  typedef struct packed {
    logic [10:0] imax;
    logic [10:0] imin;
    logic [9:0]  rdn;
    logic [9:0]  rup;
  } dsa_sol_s;

  typedef struct packed {
    logic [9:0] offs;
    logic [8:0] gain;
  } dsa_cond_s;

  typedef struct packed {
    logic       sol_b;
    logic [9:0] val;
  } dsa_fix_s;
endpackage

/* File: dsa_props.sv */
// Port checker for dsa_top: APB timing, output pairing and the hard output disables.
// Assumes pclk rising edge and presetn asynchronous active low.
`timescale 1ns/1ps
module dsa_props
  import dsa_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  din_pin,
  input wire logic [1:0]  sol_pwm,
  input wire logic        fault_out,
  input wire logic        solb_out,
  input wire logic        led_yellow,
  input wire logic        led_red,
  input wire logic        nv_save,
  input wire logic        nv_restore
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles each of pins 0 to 2 has sat low, saturating; covers sync and filter delay
  logic [3:0] low_r [3];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= '{default: 4'h0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        low_r[i] <= din_pin[i] ? 4'h0 : low_r[i] + 4'(low_r[i] != 4'hf);
      end
    end
  end
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero outside access");
  property p_red; led_red == fault_out; endproperty
  a_red: assert property (p_red) else $error("red led differs from fault output");
  property p_solb; solb_out |-> led_yellow; endproperty
  a_solb: assert property (p_solb) else $error("solenoid B output without selection");
  property p_save; psel && penable && pready && pwrite && paddr == ADDR_CTRL && pwdata[16] |=> nv_save; endproperty
  a_save: assert property (p_save) else $error("save pulse missing");
  property p_rest; nv_restore |=> !nv_restore [*3]; endproperty
  a_rest: assert property (p_rest) else $error("restore pulse repeated");
  property p_a_off; low_r[0] >= 4'h8 |-> !sol_pwm[0]; endproperty
  a_a_off: assert property (p_a_off) else $error("solenoid A driven while disabled");
  property p_b_off; low_r[1] >= 4'h8 |-> !sol_pwm[1] && !solb_out; endproperty
  a_b_off: assert property (p_b_off) else $error("solenoid B driven while disabled");
  property p_en_off; low_r[2] >= 4'h8 |-> sol_pwm == 2'h0; endproperty
  a_en_off: assert property (p_en_off) else $error("output driven without enable");
endmodule

bind dsa_top dsa_props u_dsa_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .din_pin, .sol_pwm, .fault_out, .solb_out, .led_yellow, .led_red, .nv_save, .nv_restore);

/* File: dsa_field_model.sv */
// Field side: preset encoder driving codes and pins, solenoid loads timing each PWM period.
// Assumes the common pclk; PERIOD equals the design's PWM period.
`timescale 1ns/1ps
module dsa_field_model #(
  parameter int unsigned PERIOD = 100
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [7:0]       act_in,
  input  wire logic [39:0]      codes,
  output logic      [39:0]      adc_code,
  output logic      [7:0]       din_pin,
  input  wire logic [1:0]       sol_pwm,
  output logic      [1:0][15:0] duty
);
  logic [15:0]      cnt_r;
  logic [1:0][15:0] hi_r;
  assign adc_code = codes;
  assign din_pin  = {act_in[7:2], ~act_in[1:0]};
  // High cycles per full period; any aligned window sees the same count in steady state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0;
      hi_r  <= '0;
      duty  <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        hi_r[i] <= (cnt_r == 16'(PERIOD - 1)) ? 16'h0 : hi_r[i] + 16'(sol_pwm[i]);
        if (cnt_r == 16'(PERIOD - 1)) duty[i] <= hi_r[i] + 16'(sol_pwm[i]);
      end
      cnt_r <= (cnt_r == 16'(PERIOD - 1)) ? 16'h0 : cnt_r + 16'h1;
    end
  end
endmodule

/* File: tb.sv */
// Testbench for dsa_top: APB register checks, mode mapping, enables, duty, ramp, fault.
// Assumes dsa_pkg, dsa_props bound to dsa_top and dsa_field_model.
`timescale 1ns/1ps
module tb;
  import dsa_pkg::*;
  localparam int PER = 100;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [7:0]       act_in;
  logic [39:0]      codes;
  logic [39:0]      adc_code;
  logic [7:0]       din_pin;
  logic [1:0]       sol_pwm;
  logic [1:0][15:0] duty;
  logic             fault_out;
  logic             solb_out;
  logic             led_yellow;
  logic             led_red;
  logic             nv_save;
  logic             nv_restore;
  logic [31:0]      r;
  logic             e;
  int               err_count = 0;
  int               checks = 0;
  dsa_top #(.PWM_PERIOD(PER), .RAMP_TICK(10)) u_dsa_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .adc_code, .din_pin, .sol_pwm, .fault_out, .solb_out, .led_yellow,
    .led_red, .nv_save, .nv_restore);
  dsa_field_model #(.PERIOD(PER)) u_dsa_field_model (.pclk, .presetn, .act_in, .codes, .adc_code, .din_pin,
    .sol_pwm, .duty);
  always #20 pclk = ~pclk;
  task automatic complete_run();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_count++;
      complete_run();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  function automatic logic [31:0] exp_duty(input int v, input int imax);
    return 32'((((v * imax) >> 10) * PER) / 1800);
  endfunction
  // Waits n cycles; 300 is three PWM periods so the measured duty comes from a whole period in steady state
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    act_in = 0;
    codes = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({31'h0, nv_restore}, 32'h0);
    @(negedge pclk);
    chk({31'h0, nv_restore}, 32'h1);
    rdc(ADDR_CTRL, CTRL_RST);
    rdc(ADDR_DITHER, {1'b0, DITH_AMP_RST, DITH_HP_RST});
    rdc(ADDR_LIM0 + 8'h4, {5'h0, IMAX_RST, 5'h0, IMIN_RST});
    rdc(ADDR_RAMP0 + 8'h4, 32'h0);
    rdc(ADDR_COND0 + 8'hc, {23'h0, GAIN_ONE});
    rdc(ADDR_FIX1 + 8'h18, 32'h0);
    apb(1'b1, ADDR_DITHER, 32'h0640_0031);
    rdc(ADDR_DITHER, 32'h0640_0031);
    apb(1'b1, ADDR_DITHER, {12'h0, DITH_HP_RST});
    apb(1'b0, 8'hfc, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    rdc(ADDR_STATUS, 32'h0);
    for (int k = 0; k < 4; k++) begin
      act_in <= 8'h04 | 8'(k);
      settle(8);
      rdc(ADDR_STATUS, {22'h0, ~k[1], ~k[0], 5'h0, 1'b1, 2'(k)});
    end
    act_in <= 8'h0c;
    settle(8);
    chk({31'h0, led_yellow}, 32'h1);
    act_in <= 8'h04;
    settle(8);
    chk({31'h0, led_yellow}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_CTRL, 32'(1 + k / 2));
      codes <= {10'h0, 10'(k % 2 ? 10'h300 : 10'h100), 10'h0, 10'(k % 2 ? 10'h300 : 10'h100)};
      settle(8);
      chk({31'h0, led_yellow}, 32'(k % 2 == 0));
      chk({31'h0, solb_out}, 32'(k % 2 == 0));
    end
    apb(1'b1, ADDR_CTRL, 32'h3);
    codes <= 40'h3ff;
    settle(300);
    chk(32'(duty[0]), exp_duty(1023, 1800));
    chk(32'(duty[1]), 32'h0);
    apb(1'b1, ADDR_LIM0, 32'h0384_0000);
    settle(300);
    chk(32'(duty[0]), exp_duty(1023, 900));
    apb(1'b1, ADDR_CTRL, 32'h13);
    codes <= 40'h0;
    settle(300);
    chk(32'(duty[0]), exp_duty(1023, 900));
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_FIX1, 32'h3ff);
    apb(1'b1, ADDR_FIX1 + 8'h18, 32'h200);
    act_in <= 8'he4;
    settle(300);
    chk(32'(duty[0]), exp_duty(512, 900));
    act_in <= 8'he5;
    settle(300);
    chk(32'(duty[0]), 32'h0);
    act_in <= 8'h04;
    apb(1'b1, ADDR_RAMP0, 32'h1);
    settle(300);
    act_in <= 8'h24;
    settle(300);
    chk({31'h0, duty[0] < 16'(exp_duty(1023, 900))}, 32'h1);
    act_in <= 8'h34;
    settle(300);
    chk(32'(duty[0]), exp_duty(1023, 900));
    apb(1'b1, ADDR_CTRL, 32'h0001_0103);
    @(negedge pclk);
    chk({31'h0, nv_save}, 32'h1);
    rdc(ADDR_CTRL, 32'h103);
    codes <= 40'h050;
    settle(8);
    chk({30'h0, fault_out, led_red}, 32'h3);
    codes <= 40'h3ff;
    settle(8);
    chk({30'h0, fault_out, led_red}, 32'h0);
    complete_run();
  end
endmodule
